// [motion2_regs.svh]
/*
 * Register offsets, field positions and reset values of the second inertial
 * interrupt generator, the first generator's duration register and the tap axis
 * enables. Assumes inclusion by the interrupt generator module only.
 */
`ifndef MOTION2_REGS_SVH
`define MOTION2_REGS_SVH

`define OFS_MOTION1_MIN_DURATION 8'h33
`define OFS_MOTION2_CONFIG       8'h34
`define OFS_MOTION2_SOURCE_FLAGS 8'h35
`define OFS_MOTION2_THRESHOLD    8'h36
`define OFS_MOTION2_MIN_DURATION 8'h37
`define OFS_TAP_AXIS_ENABLES     8'h38

`define RST_REG8                 8'h00
`define CFG_AND_OR_BIT           7
`define CFG_SIX_DIR_BIT          6
`define SRC_PENDING_BIT          6
`define TAP_EN_WIDTH             6

`endif

// [motion2_pkg.sv]
/*
 * Types shared by the motion interrupt generator.
 * Assumes nothing of its surroundings.
 */
package motion2_pkg;
    // Interrupt mode as decoded from and_or_select and six_direction_en.
    typedef enum logic [1:0] {
        MODE_OR,
        MODE_MOVE,
        MODE_AND,
        MODE_POSITION
    } motion_mode_t;

    typedef logic [7:0] reg8_t;
endpackage : motion2_pkg

// [persist_counter.sv]
/*
 * Persistence qualifier: a condition is recognised only after it has held for
 * the programmed number of consecutive samples. Assumes a one-cycle sample strobe.
 */
`timescale 1ns/10ps
module persist_counter #(
    parameter int CNT_W = 7
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             sample,
    input  wire logic             cond,
    input  wire logic [CNT_W-1:0] min_persist_count,
    output logic                  qualified
);
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic             qual_r;
    logic             qual_nxt;

    // Saturating count of consecutive true samples; zero length qualifies at once.
    always_comb
    begin
        cnt_nxt  = cnt_r;
        qual_nxt = qual_r;
        if (sample)
        begin
            if (!cond)
            begin
                cnt_nxt  = '0;
                qual_nxt = 1'b0;
            end
            else if (cnt_r >= min_persist_count)
            begin
                qual_nxt = 1'b1;
            end
            else
            begin
                cnt_nxt  = cnt_r + 1'b1;
                qual_nxt = (cnt_r + 1'b1) >= min_persist_count;
            end
        end
    end

    // Count and verdict registers; reset forgets any partial run of samples.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_r  <= '0;
            qual_r <= 1'b0;
        end
        else
        begin
            cnt_r  <= cnt_nxt;
            qual_r <= qual_nxt;
        end
    end

    assign qualified = qual_r;
endmodule : persist_counter

// [motion2_int_gen.sv]
/*
 * Second inertial interrupt generator with its register file, plus the first
 * generator's duration register and the tap axis enables. Assumes a simple
 * synchronous register port (address, write strobe, read strobe) from the
 * serial interface, and per-axis acceleration magnitudes with a sample strobe.
 */
`timescale 1ns/10ps
`include "motion2_regs.svh"

module motion2_int_gen (
    input  wire logic               REF_CLK,
    input  wire logic               RST_N,
    input  wire logic [7:0]         REG_ADDR,
    input  wire logic               REG_WR,
    input  wire logic               REG_RD,
    input  wire motion2_pkg::reg8_t REG_WDATA,
    output motion2_pkg::reg8_t      REG_RDATA,
    input  wire logic               SAMPLE_STB,
    input  wire logic [6:0]         ACC_X_MAG,
    input  wire logic [6:0]         ACC_Y_MAG,
    input  wire logic [6:0]         ACC_Z_MAG,
    input  wire logic               LATCH_EN,
    output logic                    MOTION2_IRQ,
    output logic [6:0]              MOTION1_MIN_DUR,
    output logic [5:0]              TAP_AXIS_EN
);
    import motion2_pkg::*;

    reg8_t        dur1_r, dur1_nxt, cfg_r, cfg_nxt, ths_r, ths_nxt, dur2_r, dur2_nxt;
    reg8_t        tap_r, tap_nxt, src_r, src_nxt, rdata_r, rdata_nxt;
    logic         irq_r, irq_nxt, known_d_r, known_d_nxt;
    motion_mode_t mode;
    logic [5:0]   raw_ev, en_ev;
    logic         comb_cond, known, fire, rd_src;

    // Reserved top bit is stored as written; the host keeps it zero.
    function automatic logic hit(input logic [7:0] a, input logic [7:0] b, input logic we);
        hit = we && (a == b);
    endfunction : hit

    // Mode decode from and_or_select and six_direction_en.
    always_comb
    begin
        case ({cfg_r[`CFG_AND_OR_BIT], cfg_r[`CFG_SIX_DIR_BIT]})
            2'b00:   mode = MODE_OR;
            2'b01:   mode = MODE_MOVE;
            2'b10:   mode = MODE_AND;
            2'b11:   mode = MODE_POSITION;
            default: mode = MODE_OR;
        endcase
    end

    // Raw events in source flag order: z above, z below, y above, ..., x below.
    always_comb
    begin
        raw_ev = {ACC_Z_MAG > ths_r[6:0], ACC_Z_MAG < ths_r[6:0],
                  ACC_Y_MAG > ths_r[6:0], ACC_Y_MAG < ths_r[6:0],
                  ACC_X_MAG > ths_r[6:0], ACC_X_MAG < ths_r[6:0]};
        en_ev  = raw_ev & cfg_r[5:0];
        // A known zone: one enabled axis event stands alone, i.e. one dominant axis.
        known  = (en_ev != 6'h00) && ((en_ev & (en_ev - 6'h01)) == 6'h00);
        case (mode)
            MODE_OR:       comb_cond = |en_ev;
            MODE_AND:      comb_cond = (cfg_r[5:0] != 6'h00) && (en_ev == cfg_r[5:0]);
            MODE_MOVE:     comb_cond = known && !known_d_r;
            MODE_POSITION: comb_cond = known;
            default:       comb_cond = 1'b0;
        endcase
    end

    // Minimum persistence measured in samples.
    persist_counter #(.CNT_W(7)) u_persist (
        .clk               (REF_CLK),
        .rst_n             (RST_N),
        .sample            (SAMPLE_STB),
        .cond              (comb_cond),
        .min_persist_count (dur2_r[6:0]),
        .qualified         (fire)
    );

    assign rd_src = REG_RD && (REG_ADDR == `OFS_MOTION2_SOURCE_FLAGS);

    // Register file, source flags and interrupt pin next state.
    always_comb
    begin
        dur1_nxt    = hit(REG_ADDR, `OFS_MOTION1_MIN_DURATION, REG_WR)
                      ? REG_WDATA : dur1_r;
        cfg_nxt     = hit(REG_ADDR, `OFS_MOTION2_CONFIG, REG_WR)
                      ? REG_WDATA : cfg_r;
        ths_nxt     = hit(REG_ADDR, `OFS_MOTION2_THRESHOLD, REG_WR)
                      ? REG_WDATA : ths_r;
        dur2_nxt    = hit(REG_ADDR, `OFS_MOTION2_MIN_DURATION, REG_WR)
                      ? REG_WDATA : dur2_r;
        tap_nxt     = hit(REG_ADDR, `OFS_TAP_AXIS_ENABLES, REG_WR)
                      ? {2'b00, REG_WDATA[5:0]} : tap_r;
        known_d_nxt = SAMPLE_STB ? known : known_d_r;
        src_nxt     = src_r;
        irq_nxt     = irq_r;
        // Read clears pending; a latched record is kept until read.
        if (rd_src)
        begin
            src_nxt[`SRC_PENDING_BIT] = 1'b0;
            irq_nxt                   = 1'b0;
            if (LATCH_EN)
                src_nxt[5:0] = 6'h00;
        end
        if (!LATCH_EN)
        begin
            // Unlatched: flags and pin follow the qualified condition.
            src_nxt[5:0] = fire ? en_ev : 6'h00;
            irq_nxt      = fire;
        end
        // A new event wins over a clear in the same cycle.
        if (fire)
        begin
            src_nxt[`SRC_PENDING_BIT] = 1'b1;
            src_nxt[5:0]              = (LATCH_EN ? src_nxt[5:0] : 6'h00) | en_ev;
            irq_nxt                   = 1'b1;
        end
        src_nxt[7] = 1'b0;
        rdata_nxt  = `RST_REG8;
        case (REG_ADDR)
            `OFS_MOTION1_MIN_DURATION: rdata_nxt = dur1_r;
            `OFS_MOTION2_CONFIG:       rdata_nxt = cfg_r;
            `OFS_MOTION2_SOURCE_FLAGS: rdata_nxt = src_r;
            `OFS_MOTION2_THRESHOLD:    rdata_nxt = ths_r;
            `OFS_MOTION2_MIN_DURATION: rdata_nxt = dur2_r;
            `OFS_TAP_AXIS_ENABLES:     rdata_nxt = tap_r;
            default:                   rdata_nxt = `RST_REG8;
        endcase
        if (!REG_RD)
            rdata_nxt = rdata_r;
    end

    // All control state resets to zero.
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            dur1_r    <= `RST_REG8;
            cfg_r     <= `RST_REG8;
            ths_r     <= `RST_REG8;
            dur2_r    <= `RST_REG8;
            tap_r     <= `RST_REG8;
            src_r     <= `RST_REG8;
            rdata_r   <= `RST_REG8;
            irq_r     <= 1'b0;
            known_d_r <= 1'b0;
        end
        else
        begin
            dur1_r    <= dur1_nxt;
            cfg_r     <= cfg_nxt;
            ths_r     <= ths_nxt;
            dur2_r    <= dur2_nxt;
            tap_r     <= tap_nxt;
            src_r     <= src_nxt;
            rdata_r   <= rdata_nxt;
            irq_r     <= irq_nxt;
            known_d_r <= known_d_nxt;
        end
    end

    assign REG_RDATA       = rdata_r;
    assign MOTION2_IRQ     = irq_r;
    assign MOTION1_MIN_DUR = dur1_r[6:0];
    assign TAP_AXIS_EN     = tap_r[`TAP_EN_WIDTH-1:0];

    // Checks kept beside the logic they guard.
    sequence s_src_read;
        rd_src && !fire;
    endsequence

    a_read_clears_pin: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        s_src_read |=> !MOTION2_IRQ && !src_r[`SRC_PENDING_BIT])
        else $error("source read did not clear pending flag");
    a_fire_sets_pin: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        fire |=> MOTION2_IRQ && src_r[`SRC_PENDING_BIT])
        else $error("qualified event did not raise interrupt");
    a_cfg_write_lands: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        REG_WR && REG_ADDR == `OFS_MOTION2_CONFIG |=> cfg_r == $past(REG_WDATA))
        else $error("configuration write lost");
    a_ths_write_lands: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        REG_WR && REG_ADDR == `OFS_MOTION2_THRESHOLD |=> ths_r == $past(REG_WDATA))
        else $error("threshold write lost");
    a_dur1_write_lands: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        REG_WR && REG_ADDR == `OFS_MOTION1_MIN_DURATION
        |=> MOTION1_MIN_DUR == $past(REG_WDATA[6:0]))
        else $error("first duration write lost");
    a_tap_write_lands: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        REG_WR && REG_ADDR == `OFS_TAP_AXIS_ENABLES |=> TAP_AXIS_EN == $past(REG_WDATA[5:0]))
        else $error("tap enable write lost");
    a_or_mode_event: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        mode == MODE_OR && SAMPLE_STB && en_ev == 6'h00 |=> !fire)
        else $error("OR mode qualified without enabled event");
    a_move_edge_only: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        mode == MODE_MOVE && SAMPLE_STB && known_d_r |=> !fire)
        else $error("movement mode repeated while zone unchanged");
    a_and_all_needed: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        mode == MODE_AND && SAMPLE_STB && en_ev != cfg_r[5:0] |=> !fire)
        else $error("AND mode qualified with an enabled event missing");
    a_unlatched_pin: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        !LATCH_EN |=> MOTION2_IRQ == $past(fire))
        else $error("unlatched pin did not follow the qualified condition");
    a_zero_dur_fast: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        SAMPLE_STB && comb_cond && dur2_r[6:0] == 7'h00 |=> fire)
        else $error("zero duration did not qualify at once");
endmodule : motion2_int_gen

// [host_model.sv]
/* Host model driving the register port with single write and read cycles.
   Assumes a free-running clock and no access before reset is released. */
`timescale 1ns/10ps
module host_model (
    input  wire logic               clk,
    output motion2_pkg::reg8_t      addr,
    output logic                    wr,
    output logic                    rd,
    output motion2_pkg::reg8_t      wdata,
    input  wire motion2_pkg::reg8_t rdata
);
    import motion2_pkg::*;
    // Idle values so the port is defined from time zero.
    initial
    begin
        addr  = 8'h00;
        wr    = 1'b0;
        rd    = 1'b0;
        wdata = 8'h00;
    end
    // Write data is inverted after use so a late sample sees garbage.
    task automatic write_reg(input reg8_t a, input reg8_t d);
        @(posedge clk);
        addr  <= a;
        wr    <= 1'b1;
        wdata <= (a inside {8'h33, 8'h35, 8'h36, 8'h37}) ? {1'b0, d[6:0]} : d;
        @(posedge clk);
        wr    <= 1'b0;
        wdata <= ~wdata;
    endtask : write_reg
    // Read data is taken half a cycle after the edge that samples the strobe, once settled.
    task automatic read_reg(input reg8_t a, output reg8_t d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask : read_reg
endmodule : host_model

// [tb_top.sv]
/* Self-checking bench for the motion interrupt generator.
   Assumes the host model for register access and drives the samples itself. */
`timescale 1ns/10ps
module tb_top;
    import motion2_pkg::*;
    logic       REF_CLK = 1'b0;
    logic       RST_N = 1'b0;
    logic       SAMPLE_STB = 1'b0;
    logic       LATCH_EN = 1'b0;
    logic [6:0] ACC_X = 7'h20, ACC_Y = 7'h20, ACC_Z = 7'h20;
    reg8_t      REG_ADDR, REG_WDATA, REG_RDATA;
    logic       REG_WR, REG_RD, IRQ;
    logic [6:0] DUR1;
    logic [5:0] TAPEN;
    int         num_errors = 0;
    int         checked = 0;
    always #5 REF_CLK = ~REF_CLK;
    motion2_int_gen uut (.REF_CLK(REF_CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR),
        .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
        .SAMPLE_STB(SAMPLE_STB), .ACC_X_MAG(ACC_X), .ACC_Y_MAG(ACC_Y), .ACC_Z_MAG(ACC_Z),
        .LATCH_EN(LATCH_EN), .MOTION2_IRQ(IRQ), .MOTION1_MIN_DUR(DUR1), .TAP_AXIS_EN(TAPEN));
    host_model host (.clk(REF_CLK), .addr(REG_ADDR), .wr(REG_WR), .rd(REG_RD),
        .wdata(REG_WDATA), .rdata(REG_RDATA));
    // Compare helpers count every check and report each mismatch at once.
    task automatic cmp8(input reg8_t g, input reg8_t e);
        checked++;
        if (g !== e)
        begin
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
            num_errors++;
        end
    endtask : cmp8
    task automatic cmp1(input logic g, input logic e);
        checked++;
        if (g !== e)
        begin
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
            num_errors++;
        end
    endtask : cmp1
    task automatic chk_rd(input reg8_t a, input reg8_t e);
        reg8_t d;
        host.read_reg(a, d);
        cmp8(d, e);
    endtask : chk_rd
    task automatic wr(input reg8_t a, input reg8_t d);
        host.write_reg(a, d);
    endtask : wr
    // One sample period: the pin settles two cycles after the strobe.
    task automatic smp(input logic [6:0] x, input logic [6:0] y, input logic [6:0] z);
        @(posedge REF_CLK);
        ACC_X      <= x;
        ACC_Y      <= y;
        ACC_Z      <= z;
        SAMPLE_STB <= 1'b1;
        @(posedge REF_CLK);
        SAMPLE_STB <= 1'b0;
        repeat (2) @(posedge REF_CLK);
        @(negedge REF_CLK);
    endtask : smp
    task automatic t_reset;
        for (int a = 8'h33; a <= 8'h38; a++) chk_rd(8'(a), 8'h00);
        chk_rd(8'h40, 8'h00);
        cmp8({1'b0, DUR1}, 8'h00);
        cmp8({2'b00, TAPEN}, 8'h00);
    endtask : t_reset
    task automatic t_regs;
        wr(8'h33, 8'h55);
        chk_rd(8'h33, 8'h55);
        cmp8({1'b0, DUR1}, 8'h55);
        wr(8'h37, 8'h7F);
        chk_rd(8'h37, 8'h7F);
        wr(8'h38, 8'hFF);
        chk_rd(8'h38, 8'h3F);
        cmp8({2'b00, TAPEN}, 8'h3F);
        wr(8'h35, 8'h7F);
        chk_rd(8'h35, 8'h00);
        wr(8'h37, 8'h00);
    endtask : t_regs
    // Latched OR on x above, then clear by read, then enable removed.
    task automatic t_or_latch;
        LATCH_EN <= 1'b1;
        wr(8'h36, 8'h20);
        chk_rd(8'h36, 8'h20);
        wr(8'h34, 8'h02);
        smp(7'h30, 7'h20, 7'h20);
        cmp1(IRQ, 1'b1);
        smp(7'h20, 7'h20, 7'h20);
        cmp1(IRQ, 1'b1);
        chk_rd(8'h35, 8'h42);
        cmp1(IRQ, 1'b0);
        chk_rd(8'h35, 8'h00);
        wr(8'h34, 8'h00);
        smp(7'h30, 7'h20, 7'h20);
        cmp1(IRQ, 1'b0);
    endtask : t_or_latch
    task automatic t_low;
        wr(8'h34, 8'h04);
        smp(7'h20, 7'h10, 7'h20);
        cmp1(IRQ, 1'b1);
        chk_rd(8'h35, 8'h44);
        cmp1(IRQ, 1'b1);
        @(posedge REF_CLK);
        LATCH_EN <= 1'b0;
        smp(7'h20, 7'h20, 7'h20);
        cmp1(IRQ, 1'b0);
    endtask : t_low
    task automatic t_and;
        wr(8'h34, 8'h8A);
        smp(7'h30, 7'h20, 7'h20);
        cmp1(IRQ, 1'b0);
        smp(7'h30, 7'h30, 7'h20);
        cmp1(IRQ, 1'b1);
        smp(7'h20, 7'h20, 7'h20);
        chk_rd(8'h35, 8'h40);
    endtask : t_and
    // Duration two: the second consecutive true sample is the first to fire.
    task automatic t_dur;
        wr(8'h34, 8'h02);
        wr(8'h37, 8'h02);
        smp(7'h30, 7'h20, 7'h20);
        cmp1(IRQ, 1'b0);
        smp(7'h30, 7'h20, 7'h20);
        cmp1(IRQ, 1'b1);
        wr(8'h37, 8'h00);
        smp(7'h20, 7'h20, 7'h20);
    endtask : t_dur
    task automatic t_move_pos;
        wr(8'h34, 8'h4A);
        smp(7'h20, 7'h20, 7'h20);
        smp(7'h30, 7'h20, 7'h20);
        cmp1(IRQ, 1'b1);
        smp(7'h30, 7'h20, 7'h20);
        cmp1(IRQ, 1'b0);
        wr(8'h34, 8'hCA);
        repeat (3) smp(7'h30, 7'h20, 7'h20);
        cmp1(IRQ, 1'b1);
        smp(7'h30, 7'h30, 7'h20);
        cmp1(IRQ, 1'b0);
    endtask : t_move_pos
    task automatic test_done;
        if (num_errors == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : test_done
    // Main sequence after six reset cycles.
    initial
    begin
        repeat (6) @(posedge REF_CLK);
        RST_N <= 1'b1;
        t_reset();
        t_regs();
        t_or_latch();
        t_low();
        t_and();
        t_dur();
        t_move_pos();
        test_done();
    end
    // Watchdog well beyond the expected run of under a thousand cycles.
    initial
    begin
        #100000;
        num_errors++;
        test_done();
    end
endmodule : tb_top
